// file: common/dcs_pkg.sv
// Purpose: constants shared by the debug control/status block
// Assumes: 8-bit registers reached through host debug commands
// Notes: command codes, field positions, reset value, write mask, ack byte, reset pulse length and decoder states
package dcs_pkg;
	localparam logic [7:0] CMD_READ_STATUS = 8'h02;
	localparam logic [7:0] CMD_WRITE_CONTROL = 8'h04;
	localparam logic [7:0] CMD_READ_CONTROL = 8'h05;
	localparam logic [7:0] ACK_BYTE = 8'hff;
	localparam logic [7:0] BREAKPOINT_OPCODE = 8'h00;
	localparam logic [7:0] CONTROL_RESET_VALUE = 8'h00;
	localparam logic [7:0] CONTROL_WRITE_MASK = 8'hf1;
	localparam int CTL_HALT_REQUEST = 7;
	localparam int CTL_BRK_ALLOW = 6;
	localparam int CTL_NOTIFY_EN = 5;
	localparam int CTL_SPIN_SEL = 4;
	localparam int CTL_DEVICE_RESET = 0;
	localparam int STAT_IDLE = 7;
	localparam int STAT_HALT = 6;
	localparam int STAT_LOCK = 5;
	localparam int RESET_PULSE_CYCLES = 16;
	typedef enum logic [1:0] {
		CMD_IDLE = 2'b00,
		CMD_WAIT_DATA = 2'b01
	} dcs_cmd_state_t;
endpackage

// file: logic/dcs_reset_seq.sv
// Purpose: timed system reset pulse started by the debug unit
// Assumes: start is a one-cycle pulse on CLK
// Notes: done pulses once the reset pulse has ended
`timescale 1ns/1ps
module dcs_reset_seq #(
	parameter int CYCLES = dcs_pkg::RESET_PULSE_CYCLES
) (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic start, // begin a reset pulse
	output logic sys_reset, // reset to the rest of the device
	output logic done // one-cycle pulse at end
);
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic sys_reset_reg;
	logic sys_reset_next;
	logic done_reg;
	logic done_next;

	always_comb
	begin
		count_next = count_reg;
		sys_reset_next = sys_reset_reg;
		done_next = 1'b0;
		if (start && !sys_reset_reg)
		begin
			sys_reset_next = 1'b1;
			count_next = 8'(CYCLES - 1);
		end
		else if (sys_reset_reg)
		begin
			if (count_reg == 8'h00)
			begin
				sys_reset_next = 1'b0;
				done_next = 1'b1;
			end
			else
			begin
				count_next = count_reg - 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			count_reg <= 8'h00;
			sys_reset_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			sys_reset_reg <= sys_reset_next;
			done_reg <= done_next;
		end
	end

	assign sys_reset = sys_reset_reg;
	assign done = done_reg;
endmodule

// file: logic/dcs_top.sv
// Purpose: debug unit control and status registers with host command decode
// Assumes: host bytes arrive as strobed bytes on CLK; cpu signals on CLK
// Notes: RESETN is the debug unit's own reset; SYS_RESET is not fed back
// Notes: with bit 4 clear, a breakpoint beats a same-cycle host write to bit 7
// Notes: lock and halt pins pass two flops before any logic reads them
// Notes on behaviour
// - writing 81h resets the device and leaves the cpu stopped
// - writing 41h resets the device and lets the cpu run
// - writing 40h in debug mode resumes execution
// - control bit 7 halts instruction fetch; clearing it resumes
// - enabled breakpoint opcode with bit 4 clear sets control bit 7 by hardware
// - with readout lock, writing 0 to bit 7 is ignored
// - bit 6 clear makes opcode 00h a no-op; set makes it a breakpoint
// - bit 5 set sends ffh to host on every breakpoint
// - breakpoint with bit 4 clear sets bit 7 and enters debug mode
// - breakpoint with bit 4 set makes the cpu spin on the opcode
// - control bit 0 resets the device but not the debug unit
// - control bit 0 clears itself when that reset completes
// - status bit 7 reads 1 in debug mode
// - status bit 7 reads 1 after a breakpoint since last control write
// - status bit 6 reads 1 while in halt low-power state
// - status bit 5 reads 1 when readout lock option bit is 0
// - status low bits read 0; status register is read-only
// - command 04h plus one data byte writes the control register
// - command 05h returns the control register
// - command 02h returns the status register
`timescale 1ns/1ps
module dcs_top #(
	parameter int RESET_CYCLES = dcs_pkg::RESET_PULSE_CYCLES
) (
	input wire logic CLK, // system clock
	input wire logic RESETN, // async reset, active low
	input wire logic RX_VALID, // host byte strobe
	input wire logic [7:0] RX_DATA, // host byte
	output logic TX_VALID, // reply byte strobe
	output logic [7:0] TX_DATA, // reply byte
	input wire logic OPCODE_VALID, // cpu decoded an opcode
	input wire logic [7:0] OPCODE, // decoded opcode
	input wire logic HALT_STATE, // cpu in halt low-power state
	input wire logic LOCK_OPTION_N, // readout lock option bit, 0 = on
	output logic CPU_STOP, // stop instruction fetch
	output logic CPU_SPIN, // re-execute breakpoint opcode
	output logic CPU_NOP, // treat current opcode as no-op
	output logic SYS_RESET // reset to rest of device
);
	dcs_pkg::dcs_cmd_state_t state_reg;
	dcs_pkg::dcs_cmd_state_t state_next;
	logic [7:0] control_reg;
	logic [7:0] control_next;
	logic brk_seen_reg;
	logic brk_seen_next;
	logic spin_reg;
	logic spin_next;
	logic nop_reg;
	logic nop_next;
	logic tx_valid_reg;
	logic tx_valid_next;
	logic [7:0] tx_data_reg;
	logic [7:0] tx_data_next;
	localparam int SYNC_COUNT = 2;
	localparam int SYNC_HALT = 0;
	localparam int SYNC_LOCK = 1;
	// lock idles unlocked (high), halt idles low
	localparam logic [SYNC_COUNT-1:0] SYNC_IDLE = 2'h2;
	logic [SYNC_COUNT-1:0] sync_in;
	logic [SYNC_COUNT-1:0] sync_out;
	logic reset_start_reg;
	logic reset_start_next;
	logic reset_done;
	logic [7:0] status_value;
	logic brk_hit;
	logic ctl_write;

	function automatic logic is_breakpoint(input logic valid, input logic [7:0] op);
		is_breakpoint = valid && (op == dcs_pkg::BREAKPOINT_OPCODE);
	endfunction

	function automatic logic is_command(input logic valid, input logic [7:0] data, input logic [7:0] code);
		is_command = valid && (data == code);
	endfunction

	dcs_reset_seq #(
		.CYCLES(RESET_CYCLES)
	) u_reset_seq (
		.clk(CLK),
		.resetn(RESETN),
		.start(reset_start_reg),
		.sys_reset(SYS_RESET),
		.done(reset_done)
	);

	// status word, low bits always zero
	always_comb
	begin
		status_value = 8'h00;
		status_value[dcs_pkg::STAT_IDLE] = control_reg[dcs_pkg::CTL_HALT_REQUEST] || brk_seen_reg;
		status_value[dcs_pkg::STAT_HALT] = sync_out[SYNC_HALT];
		status_value[dcs_pkg::STAT_LOCK] = !sync_out[SYNC_LOCK];
	end

	assign brk_hit = is_breakpoint(OPCODE_VALID, OPCODE) && control_reg[dcs_pkg::CTL_BRK_ALLOW];
	assign ctl_write = (state_reg == dcs_pkg::CMD_WAIT_DATA) && RX_VALID;
	assign sync_in[SYNC_HALT] = HALT_STATE;
	assign sync_in[SYNC_LOCK] = LOCK_OPTION_N;

	// two flops on each pin from outside the clock domain
	for (genvar g = 0; g < SYNC_COUNT; g++)
	begin : g_sync
		logic s1_reg;
		logic s1_next;
		logic s2_reg;
		logic s2_next;

		always_comb
		begin
			s1_next = sync_in[g];
			s2_next = s1_reg;
		end

		always_ff @(posedge CLK or negedge RESETN)
		begin
			if (!RESETN)
			begin
				s1_reg <= SYNC_IDLE[g];
				s2_reg <= SYNC_IDLE[g];
			end
			else
			begin
				s1_reg <= s1_next;
				s2_reg <= s2_next;
			end
		end

		assign sync_out[g] = s2_reg;
	end

	// host command decoder
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			dcs_pkg::CMD_IDLE:
			begin
				// read commands answer at once, other bytes are ignored
				if (is_command(RX_VALID, RX_DATA, dcs_pkg::CMD_WRITE_CONTROL))
				begin
					state_next = dcs_pkg::CMD_WAIT_DATA;
				end
			end
			dcs_pkg::CMD_WAIT_DATA:
			begin
				if (RX_VALID)
				begin
					state_next = dcs_pkg::CMD_IDLE;
				end
			end
			default:
			begin
				state_next = dcs_pkg::CMD_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_reg <= dcs_pkg::CMD_IDLE;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// control register and breakpoint record
	always_comb
	begin
		control_next = control_reg;
		brk_seen_next = brk_seen_reg;
		reset_start_next = 1'b0;
		if (ctl_write)
		begin
			// reserved bits kept zero whatever the host sends
			control_next = RX_DATA & dcs_pkg::CONTROL_WRITE_MASK;
			// under lock the halt bit only leaves by a unit reset
			if (!sync_out[SYNC_LOCK] && control_reg[dcs_pkg::CTL_HALT_REQUEST])
			begin
				control_next[dcs_pkg::CTL_HALT_REQUEST] = 1'b1;
			end
			brk_seen_next = 1'b0;
			reset_start_next = RX_DATA[dcs_pkg::CTL_DEVICE_RESET];
		end
		// breakpoint wins over a same-cycle control write
		if (brk_hit)
		begin
			brk_seen_next = 1'b1;
			if (!control_reg[dcs_pkg::CTL_SPIN_SEL])
			begin
				control_next[dcs_pkg::CTL_HALT_REQUEST] = 1'b1;
			end
		end
		// a host write in the same cycle keeps its own bit 0
		if (reset_done && !ctl_write)
		begin
			control_next[dcs_pkg::CTL_DEVICE_RESET] = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			control_reg <= dcs_pkg::CONTROL_RESET_VALUE;
			brk_seen_reg <= 1'b0;
			reset_start_reg <= 1'b0;
		end
		else
		begin
			control_reg <= control_next;
			brk_seen_reg <= brk_seen_next;
			reset_start_reg <= reset_start_next;
		end
	end

	// reply byte to the host
	always_comb
	begin
		tx_valid_next = 1'b0;
		tx_data_next = tx_data_reg;
		if (state_reg == dcs_pkg::CMD_IDLE)
		begin
			if (is_command(RX_VALID, RX_DATA, dcs_pkg::CMD_READ_CONTROL))
			begin
				tx_valid_next = 1'b1;
				tx_data_next = control_reg;
			end
			else if (is_command(RX_VALID, RX_DATA, dcs_pkg::CMD_READ_STATUS))
			begin
				tx_valid_next = 1'b1;
				tx_data_next = status_value;
			end
		end
		// the acknowledge byte wins over a same-cycle read reply
		if (brk_hit && control_reg[dcs_pkg::CTL_NOTIFY_EN])
		begin
			tx_valid_next = 1'b1;
			tx_data_next = dcs_pkg::ACK_BYTE;
		end
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
		end
		else
		begin
			tx_valid_reg <= tx_valid_next;
			tx_data_reg <= tx_data_next;
		end
	end

	// one-cycle cpu pulses for a decoded breakpoint opcode
	always_comb
	begin
		spin_next = 1'b0;
		nop_next = 1'b0;
		if (is_breakpoint(OPCODE_VALID, OPCODE))
		begin
			if (!control_reg[dcs_pkg::CTL_BRK_ALLOW])
			begin
				nop_next = 1'b1;
			end
			else if (control_reg[dcs_pkg::CTL_SPIN_SEL])
			begin
				spin_next = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			spin_reg <= 1'b0;
			nop_reg <= 1'b0;
		end
		else
		begin
			spin_reg <= spin_next;
			nop_reg <= nop_next;
		end
	end

	assign TX_VALID = tx_valid_reg;
	assign TX_DATA = tx_data_reg;
	assign CPU_STOP = control_reg[dcs_pkg::CTL_HALT_REQUEST];
	assign CPU_SPIN = spin_reg;
	assign CPU_NOP = nop_reg;
endmodule

// file: sim/dcs_top_asserts.sv
// Purpose: port checks for dcs_top
// Assumes: one clock, RESETN async
// Notes: shadows control bits 6..4
`timescale 1ns/1ps
module dcs_chk #(
	parameter int RESET_CYCLES = 16
) (
	input wire logic CLK, // clock
	input wire logic RESETN, // reset
	input wire logic RX_VALID, // host strobe
	input wire logic [7:0] RX_DATA, // host byte
	input wire logic TX_VALID, // reply strobe
	input wire logic [7:0] TX_DATA, // reply byte
	input wire logic OPCODE_VALID, // opcode strobe
	input wire logic [7:0] OPCODE, // opcode
	input wire logic CPU_STOP, // stop
	input wire logic CPU_SPIN, // spin
	input wire logic CPU_NOP, // no-op
	input wire logic SYS_RESET // device reset
);
	logic wait_reg;
	logic [2:0] ctl_reg;
	int run_reg;
	wire logic dat = RX_VALID && wait_reg;
	wire logic cmd = RX_VALID && !wait_reg;
	wire logic breakpoint_opcode = OPCODE_VALID && OPCODE == 8'h00;
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			wait_reg <= 1'b0;
			ctl_reg <= 3'h0;
			run_reg <= 0;
		end
		else
		begin
			if (RX_VALID)
				wait_reg <= cmd && RX_DATA == 8'h04;
			if (dat)
				ctl_reg <= RX_DATA[6:4];
			run_reg <= SYS_RESET ? run_reg + 1 : 0;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	sequence s_brk_on;
		breakpoint_opcode && ctl_reg[2];
	endsequence
	sequence s_wr(int b);
		dat && RX_DATA[b];
	endsequence
	chk_read_reply: assert property (cmd && (RX_DATA == 8'h02 || RX_DATA == 8'h05) |=> TX_VALID)
		else $error("no reply");
	chk_stop_write: assert property (s_wr(7) |-> ##[1:2] CPU_STOP)
		else $error("no stop");
	chk_brk_stop: assert property (s_brk_on ##0 !ctl_reg[0] |-> ##[1:2] CPU_STOP)
		else $error("no stop on break");
	chk_brk_spin: assert property (s_brk_on ##0 ctl_reg[0] |=> CPU_SPIN)
		else $error("no spin");
	chk_brk_ack: assert property (s_brk_on ##0 ctl_reg[1] |=> TX_VALID && TX_DATA == 8'hff)
		else $error("no ack byte");
	chk_brk_nop: assert property (breakpoint_opcode && !ctl_reg[2] |=> CPU_NOP && !CPU_SPIN)
		else $error("no nop");
	chk_reset_start: assert property (s_wr(0) |-> ##[1:3] SYS_RESET)
		else $error("no device reset");
	chk_reset_len: assert property ($fell(SYS_RESET) |-> run_reg == RESET_CYCLES)
		else $error("reset length");
endmodule
bind dcs_top dcs_chk #(.RESET_CYCLES(RESET_CYCLES)) i_dcs_chk (.CLK(CLK), .RESETN(RESETN), .RX_VALID(RX_VALID),
	.RX_DATA(RX_DATA), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .OPCODE_VALID(OPCODE_VALID), .OPCODE(OPCODE),
	.CPU_STOP(CPU_STOP), .CPU_SPIN(CPU_SPIN), .CPU_NOP(CPU_NOP), .SYS_RESET(SYS_RESET));

// file: sim/dcs_host.sv
// Purpose: debug host model
// Assumes: byte strobes on CLK
// Notes: released data line shows inverse
`timescale 1ns/1ps
module dcs_host (
	input wire logic CLK, // clock
	output logic RX_VALID, // byte strobe
	output logic [7:0] RX_DATA, // byte out
	input wire logic TX_VALID, // reply strobe
	input wire logic [7:0] TX_DATA // reply byte
);
	int n_rx = 0;
	logic [7:0] last = 8'h00;
	initial
	begin
		RX_VALID = 1'b0;
		RX_DATA = 8'hff;
	end
	always @(posedge CLK)
		if (TX_VALID)
		begin
			last <= TX_DATA;
			n_rx <= n_rx + 1;
		end
	task send(input logic [7:0] b);
		@(posedge CLK) #1 RX_VALID = 1'b1;
		RX_DATA = b;
		@(posedge CLK) #1 RX_VALID = 1'b0;
		RX_DATA = ~b;
	endtask
	task wr(input logic [7:0] v);
		send(8'h04);
		send(v & 8'hf1);
	endtask
	task rd(input logic [7:0] c, output logic [7:0] v);
		int k;
		send(c);
		k = n_rx;
		repeat (3) if (n_rx == k) @(posedge CLK) #1;
		v = (n_rx != k) ? last : 8'hxx;
	endtask
endmodule

// file: sim/dcs_top_tb.sv
// Purpose: self-checking bench for dcs_top
// Assumes: host model sends commands
// Notes: self-reset pulse shortened to 2
`timescale 1ns/1ps
module dcs_top_tb;
	logic CLK;
	logic RESETN;
	logic OPCODE_VALID;
	logic HALT_STATE;
	logic LOCK_OPTION_N;
	logic [7:0] OPCODE;
	logic [7:0] d;
	logic RX_VALID, TX_VALID, CPU_STOP, CPU_SPIN, CPU_NOP, SYS_RESET;
	logic [7:0] RX_DATA, TX_DATA;
	int miscompares = 0;
	int total_checks = 0;
	dcs_top #(.RESET_CYCLES(2)) i_dcs_top (.CLK(CLK), .RESETN(RESETN), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
		.TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .OPCODE_VALID(OPCODE_VALID), .OPCODE(OPCODE),
		.HALT_STATE(HALT_STATE), .LOCK_OPTION_N(LOCK_OPTION_N), .CPU_STOP(CPU_STOP), .CPU_SPIN(CPU_SPIN),
		.CPU_NOP(CPU_NOP), .SYS_RESET(SYS_RESET));
	dcs_host i_dcs_host (.CLK(CLK), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA));
	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task breakpoint_opcode(input logic [7:0] op);
		@(posedge CLK) #1 OPCODE_VALID = 1'b1;
		OPCODE = op;
		@(posedge CLK) #1 OPCODE_VALID = 1'b0;
	endtask
	task t_stop_run;
		i_dcs_host.rd(8'h05, d);
		chk("control", 8'h00, d);
		i_dcs_host.wr(8'h80);
		repeat (2) @(posedge CLK) #1;
		chk("stop", 8'h01, CPU_STOP);
		i_dcs_host.rd(8'h02, d);
		chk("status", 8'h80, d);
		i_dcs_host.wr(8'h40);
		repeat (2) @(posedge CLK) #1;
		chk("run", 8'h00, CPU_STOP);
	endtask
	task t_brk;
		breakpoint_opcode(8'h00);
		@(posedge CLK) #1;
		chk("break stop", 8'h01, CPU_STOP);
		i_dcs_host.wr(8'h70);
		breakpoint_opcode(8'h00);
		chk("spin", 8'h01, CPU_SPIN);
		chk("ack", 8'hff, TX_VALID ? TX_DATA : 8'h00);
		i_dcs_host.rd(8'h02, d);
		chk("loop status", 8'h80, d);
		i_dcs_host.wr(8'h00);
		i_dcs_host.rd(8'h02, d);
		chk("cleared status", 8'h00, d);
		breakpoint_opcode(8'h00);
		chk("nop", 8'h01, CPU_NOP);
		breakpoint_opcode(8'h01);
		chk("plain op", 8'h00, {CPU_NOP, CPU_SPIN, CPU_STOP});
	endtask
	task t_lock;
		LOCK_OPTION_N = 1'b0;
		HALT_STATE = 1'b1;
		i_dcs_host.wr(8'h80);
		i_dcs_host.wr(8'h00);
		repeat (2) @(posedge CLK) #1;
		chk("locked stop", 8'h01, CPU_STOP);
		i_dcs_host.rd(8'h02, d);
		chk("lock status", 8'he0, d);
		LOCK_OPTION_N = 1'b1;
		HALT_STATE = 1'b0;
	endtask
	task t_sys_reset(input logic [7:0] v, input logic [7:0] exp);
		int i;
		i_dcs_host.wr(v);
		for (i = 0; i < 9 && !SYS_RESET; i++) @(posedge CLK) #1;
		chk("sys reset", 8'h01, SYS_RESET);
		for (i = 0; i < 9 && SYS_RESET; i++) @(posedge CLK) #1;
		chk("sys reset end", 8'h00, SYS_RESET);
		i_dcs_host.rd(8'h05, d);
		chk("after reset", exp, d);
		chk("stop after", {7'h00, exp[7]}, CPU_STOP);
	endtask
	initial
	begin
		RESETN = 1'b0;
		OPCODE_VALID = 1'b0;
		OPCODE = 8'h00;
		HALT_STATE = 1'b0;
		LOCK_OPTION_N = 1'b1;
		repeat (10) @(posedge CLK);
		#1 RESETN = 1'b1;
		t_stop_run;
		t_brk;
		t_lock;
		t_sys_reset(8'h81, 8'h80);
		t_sys_reset(8'h41, 8'h40);
		end_sim;
	end
	initial
	begin
		#20000;
		miscompares++;
		end_sim;
	end
endmodule
